//--- design/tds_pkg.sv
// Purpose: constants and lookups for teletext display sync and position
// Assumes: 25 MHz sys_clk, sync pins synchronous to it
// Notes: register map is a plain address/strobe port
// Notes on behaviour
// [R1] vsync edge in first half of line: even field, field output low
// [R2] vsync edge in second half of line: odd field, field output high
// [R3] parity decision consistent for any vsync phase, including start and midpoint
// [R4] force-low bit holds field output at 0
// [R5] auto-gate bit forces field output to 0 while any video shows
// [R6] parity-invert bit flips odd/even assumption of the vertical timing
// [R7] with parity inverted display may start one line later
// [R8] parity-invert bit never changes the field output
// [R9] two hpos bits pick 17.2, 16.2, 15.2 or 14.2 us from hsync
// [R10] 625-line: vpos codes pick lines 42,44,46,48,34,36,38,40
// [R11] 525-line: vpos codes pick lines 28,30,32,34,20,22,24,26
// [R12] other field starts on the equivalent line
// [R13] sync polarity bit 0 means positive-going, 1 negative-going
// [R14] horizontal timing restarts on every hsync leading edge
// [R15] horizontal display area lasts 40 us
// [R16] vertical area lasts 250 lines or to field end; resync each vsync
// [R17] line count between vsyncs chooses 625 or 525 table
package tds_pkg;
   localparam int CLK_MHZ = 25;
   localparam int LINE_W  = 11;
   localparam int VLINE_W = 10;
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 8;

   // register indices
   localparam logic [3:0] REG_CTRL_A   = 4'h0;
   localparam logic [3:0] REG_CTRL_B   = 4'h1;
   localparam logic [3:0] REG_POSITION = 4'h2;
   localparam logic [3:0] REG_STATUS   = 4'h3;

   // field positions
   localparam int CA_FORCE_LOW = 0;
   localparam int CA_AUTO_GATE = 1;
   localparam int CB_INVERT    = 0;
   localparam int CB_HPOL      = 1;
   localparam int CB_VPOL      = 2;
   localparam int POS_H_LSB    = 0;
   localparam int POS_V_LSB    = 2;
   localparam int ST_ODD       = 0;
   localparam int ST_525       = 1;
   localparam int ST_VDISP     = 2;

   // reset values
   localparam logic [7:0] CTRL_A_RST   = 8'h00;
   localparam logic [7:0] CTRL_B_RST   = 8'h00;
   localparam logic [7:0] POSITION_RST = 8'h00;

   // timing in ns, converted to cycles
   localparam int HPOS0_NS  = 17200;
   localparam int HPOS1_NS  = 16200;
   localparam int HPOS2_NS  = 15200;
   localparam int HPOS3_NS  = 14200;
   localparam int HDISP_NS  = 40000;
   localparam int HPOS0_CYC = HPOS0_NS * CLK_MHZ / 1000;
   localparam int HPOS1_CYC = HPOS1_NS * CLK_MHZ / 1000;
   localparam int HPOS2_CYC = HPOS2_NS * CLK_MHZ / 1000;
   localparam int HPOS3_CYC = HPOS3_NS * CLK_MHZ / 1000;
   localparam int HDISP_CYC = HDISP_NS * CLK_MHZ / 1000;

   // vertical figures
   localparam int VDISP_LINES  = 250;
   localparam int MODE_THRESH  = 288;  // lines per field between 262 and 312
   localparam int L625_BASE_LO = 42;
   localparam int L625_BASE_HI = 34;
   localparam int L525_BASE_LO = 28;
   localparam int L525_BASE_HI = 20;
   localparam int VPOS_STEP    = 2;

   // hsync to display start, in cycles
   function automatic logic [LINE_W-1:0] hpos_delay(input logic [1:0] sel);
      case (sel)
         2'h0:    hpos_delay = LINE_W'(HPOS0_CYC);
         2'h1:    hpos_delay = LINE_W'(HPOS1_CYC);
         2'h2:    hpos_delay = LINE_W'(HPOS2_CYC);
         default: hpos_delay = LINE_W'(HPOS3_CYC);
      endcase
   endfunction : hpos_delay

   // first display line for the selected table
   function automatic logic [VLINE_W-1:0] first_line(input logic       m525,
                                                     input logic [2:0] sel);
      int base;
      base = m525 ? (sel[2] ? L525_BASE_HI : L525_BASE_LO)
                  : (sel[2] ? L625_BASE_HI : L625_BASE_LO);
      first_line = VLINE_W'(base + VPOS_STEP * int'(sel[1:0]));
   endfunction : first_line
endpackage : tds_pkg

//--- design/tds_sync_edge.sv
// Purpose: polarity select and leading-edge pulse for one sync input
// Assumes: sync pin already synchronous to sys_clk
// Notes: pulse comes one cycle after the pin moves
`timescale 1ns/10ps
module tds_sync_edge (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic ce,
   input  wire logic sync_in,
   input  wire logic pol_sel,
   output logic      edge_pulse
);
   logic level;
   logic prior;

   assign level = sync_in ^ pol_sel;  // R13

   // remember last level; pulse on active-going edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prior      <= 1'b0;
         edge_pulse <= 1'b0;
      end else if (ce) begin
         prior      <= level;
         edge_pulse <= level & ~prior;  // R13
      end
   end
endmodule : tds_sync_edge

//--- design/tds_hwin.sv
// Purpose: horizontal counter and display window
// Assumes: h_edge is a one-cycle pulse
// Notes: counter saturates if hsync goes missing
`timescale 1ns/10ps
module tds_hwin #(
   parameter int LINE_W = tds_pkg::LINE_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic              h_edge,
   input  wire logic [1:0]        hpos_sel,
   output logic      [LINE_W-1:0] hcount,
   output logic                   hwin
);
   logic [LINE_W-1:0] start;
   logic [LINE_W-1:0] stop;

   assign start = tds_pkg::hpos_delay(hpos_sel);  // R9
   assign stop  = start + LINE_W'(tds_pkg::HDISP_CYC);  // R15

   // count from the hsync edge, restart on every edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hcount <= '0;
      end else if (ce) begin
         if (h_edge) begin
            hcount <= '0;  // R14
         end else if (hcount != '1) begin
            hcount <= hcount + 1'b1;
         end
      end
   end

   // window opens at start, closes 40 us later
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hwin <= 1'b0;
      end else if (ce) begin
         if (h_edge) begin
            hwin <= 1'b0;  // R14
         end else if (hcount == start) begin
            hwin <= 1'b1;  // R9
         end else if (hcount == stop) begin
            hwin <= 1'b0;  // R15
         end
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_hwin_opens: assert property (ce && !h_edge && hcount == start |=> hwin) // R9
      else $error("window did not open at selected delay");
   a_hwin_width: assert property (ce && !h_edge && hwin && hcount == stop |=> !hwin) // R15
      else $error("window not closed after 40 us");
endmodule : tds_hwin

//--- design/tds_display_sync.sv
// Purpose: teletext field parity, field output and display window position
// Assumes: sync pins synchronous; video_on high while any video shows
// Notes: field parity measured against the last full line period
`timescale 1ns/10ps
module tds_display_sync #(
   parameter int ADDR_W  = tds_pkg::ADDR_W,
   parameter int DATA_W  = tds_pkg::DATA_W,
   parameter int LINE_W  = tds_pkg::LINE_W,
   parameter int VLINE_W = tds_pkg::VLINE_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic              hsync_in,
   input  wire logic              vsync_in,
   input  wire logic              video_on,
   output logic                   field_out,
   output logic                   disp_window
);
   logic [7:0]         display_ctrl_a;
   logic [7:0]         display_ctrl_b;
   logic [7:0]         display_position_ctrl;
   logic               h_edge;
   logic               v_edge;
   logic [LINE_W-1:0]  hcount;
   logic               hwin;
   logic [LINE_W-1:0]  line_len;
   logic [LINE_W-1:0]  half_len;
   logic               raw_odd;
   logic               vert_odd;
   logic               mode_525;
   logic [VLINE_W-1:0] vline;
   logic [VLINE_W-1:0] next_vline;
   logic [VLINE_W-1:0] first_eff;
   logic [VLINE_W-1:0] last_eff;
   logic               vdisp;
   logic               next_field;
   logic               field_out_force_low;
   logic               field_out_auto_gate;
   logic               field_parity_invert;
   logic               hsync_polarity_sel;
   logic               vsync_polarity_sel;
   logic [1:0]         hpos_sel;
   logic [2:0]         vpos_sel;

   assign field_out_force_low = display_ctrl_a[tds_pkg::CA_FORCE_LOW];
   assign field_out_auto_gate = display_ctrl_a[tds_pkg::CA_AUTO_GATE];
   assign field_parity_invert = display_ctrl_b[tds_pkg::CB_INVERT];
   assign hsync_polarity_sel  = display_ctrl_b[tds_pkg::CB_HPOL];
   assign vsync_polarity_sel  = display_ctrl_b[tds_pkg::CB_VPOL];
   assign hpos_sel = display_position_ctrl[tds_pkg::POS_H_LSB +: 2];
   assign vpos_sel = display_position_ctrl[tds_pkg::POS_V_LSB +: 3];

   // sync edge detectors, one per pin
   tds_sync_edge u_hedge (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .ce         (ce),
      .sync_in    (hsync_in),
      .pol_sel    (hsync_polarity_sel),
      .edge_pulse (h_edge)
   );

   tds_sync_edge u_vedge (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .ce         (ce),
      .sync_in    (vsync_in),
      .pol_sel    (vsync_polarity_sel),
      .edge_pulse (v_edge)
   );

   tds_hwin #(.LINE_W(LINE_W)) u_hwin (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .h_edge   (h_edge),
      .hpos_sel (hpos_sel),
      .hcount   (hcount),
      .hwin     (hwin)
   );

   // register writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         display_ctrl_a        <= tds_pkg::CTRL_A_RST;
         display_ctrl_b        <= tds_pkg::CTRL_B_RST;
         display_position_ctrl <= tds_pkg::POSITION_RST;
      end else if (ce && wr_stb) begin
         if (addr == ADDR_W'(tds_pkg::REG_CTRL_A)) begin
            display_ctrl_a <= wdata;
         end else if (addr == ADDR_W'(tds_pkg::REG_CTRL_B)) begin
            display_ctrl_b <= wdata;
         end else if (addr == ADDR_W'(tds_pkg::REG_POSITION)) begin
            display_position_ctrl <= wdata;
         end
      end
   end

   // read data valid only the cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd_stb) begin
            if (addr == ADDR_W'(tds_pkg::REG_CTRL_A)) begin
               rdata <= display_ctrl_a;
            end else if (addr == ADDR_W'(tds_pkg::REG_CTRL_B)) begin
               rdata <= display_ctrl_b;
            end else if (addr == ADDR_W'(tds_pkg::REG_POSITION)) begin
               rdata <= display_position_ctrl;
            end else if (addr == ADDR_W'(tds_pkg::REG_STATUS)) begin
               rdata[tds_pkg::ST_ODD]   <= raw_odd;
               rdata[tds_pkg::ST_525]   <= mode_525;
               rdata[tds_pkg::ST_VDISP] <= vdisp;
            end
         end
      end
   end

   // line period measured at every hsync, used to find mid-line
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         line_len <= '0;
      end else if (ce && h_edge) begin
         line_len <= hcount + 1'b1;
      end
   end

   assign half_len = line_len >> 1;

   // parity from vsync phase; hcount lags the pin by a cycle, so an exact
   // mid-line vsync still reads first half and a start-of-line one is even
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         raw_odd <= 1'b0;
      end else if (ce && v_edge) begin
         if (h_edge) begin
            raw_odd <= 1'b0;  // R3
         end else begin
            raw_odd <= (hcount >= half_len);  // R1 R2 R3
         end
      end
   end

   assign vert_odd = raw_odd ^ field_parity_invert;  // R6

   // field output ignores the invert bit on purpose
   always_comb begin
      next_field = raw_odd;  // R8
      if (field_out_force_low) begin
         next_field = 1'b0;  // R4
      end else if (field_out_auto_gate && video_on) begin
         next_field = 1'b0;  // R5
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         field_out <= 1'b0;
      end else if (ce) begin
         field_out <= next_field;  // R1 R2 R4 R5
      end
   end

   // line counter: 1 at vsync, counts hsync edges
   assign next_vline = (vline == '1) ? vline : vline + 1'b1;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         vline <= '0;
      end else if (ce) begin
         if (v_edge) begin
            vline <= VLINE_W'(1);  // R16
         end else if (h_edge) begin
            vline <= next_vline;
         end
      end
   end

   // system detection from lines seen in the field just ended
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_525 <= 1'b0;
      end else if (ce && v_edge) begin
         mode_525 <= (vline < VLINE_W'(tds_pkg::MODE_THRESH));  // R17
      end
   end

   // odd vertical field starts a line later so both fields overlay;
   // with the invert bit set this is the allowed one-line delay
   assign first_eff = tds_pkg::first_line(mode_525, vpos_sel)
                      + VLINE_W'(vert_odd);  // R10 R11 R12 R7
   assign last_eff  = first_eff + VLINE_W'(tds_pkg::VDISP_LINES);  // R16

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         vdisp <= 1'b0;
      end else if (ce) begin
         if (v_edge) begin
            vdisp <= 1'b0;  // R16
         end else if (h_edge && next_vline == first_eff) begin
            vdisp <= 1'b1;  // R10 R11 R12
         end else if (h_edge && next_vline == last_eff) begin
            vdisp <= 1'b0;  // R16
         end
      end
   end

   // combined window, registered for a clean output
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         disp_window <= 1'b0;
      end else if (ce) begin
         disp_window <= hwin & vdisp;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_even_parity: assert property (ce && v_edge && !h_edge && hcount < half_len |=> !raw_odd) // R1
      else $error("early vsync not taken as even field");
   a_odd_parity: assert property (ce && v_edge && !h_edge && hcount >= half_len |=> raw_odd) // R2
      else $error("late vsync not taken as odd field");
   a_field_forced: assert property (ce && field_out_force_low |=> !field_out) // R4
      else $error("field output not held low");
   a_field_auto: assert property (ce && field_out_auto_gate && video_on |=> !field_out) // R5
      else $error("field output not gated by video");
   a_field_follows: assert property (ce && !field_out_force_low && !field_out_auto_gate // R8
                                     |=> field_out == $past(raw_odd))
      else $error("field output not following raw parity");
   a_mode_detect: assert property (ce && v_edge |=> mode_525 == // R17
                                   ($past(vline) < VLINE_W'(tds_pkg::MODE_THRESH)))
      else $error("line system detection wrong");
   a_vsync_resync: assert property (ce && v_edge |=> vline == VLINE_W'(1) && !vdisp) // R16
      else $error("vertical timing not restarted");
   a_vwin_start: assert property (ce && !v_edge && h_edge && next_vline == first_eff // R10
                                  |=> vdisp)
      else $error("display did not start on first line");
   a_vwin_end: assert property (ce && !v_edge && h_edge && next_vline == last_eff // R16
                                && next_vline != first_eff |=> !vdisp)
      else $error("display not ended after 250 lines");
   a_window_and: assert property (ce |=> disp_window == ($past(hwin) && $past(vdisp)))
      else $error("window output mismatch");

   // parity only moves at a vsync edge
   a_parity_hold: assert property (ce && !v_edge |=> $stable(raw_odd)) // R1 R2
      else $error("parity changed inside a field");

   // vsync on the hsync edge is a line start: even
   a_start_even: assert property (ce && v_edge && h_edge |=> !raw_odd) // R3
      else $error("vsync at line start not even");

   // mid-line test needs the last full line period
   a_line_period: assert property (ce && h_edge // R3
                                   |=> line_len == $past(hcount) + 1'b1)
      else $error("line period not captured");

   // only a vsync edge may change the line system
   a_mode_hold: assert property (ce && !v_edge |=> $stable(mode_525)) // R17
      else $error("line system changed inside a field");

   // each hsync inside a field adds one line
   a_line_step: assert property (ce && !v_edge && h_edge // R16
                                 |=> vline == $past(next_vline))
      else $error("line count did not step");

   // odd vertical field: nothing opens on the nominal line
   a_odd_delay: assert property (ce && !v_edge && h_edge && vert_odd && !vdisp // R6 R7 R12
                                 && next_vline == tds_pkg::first_line(mode_525, vpos_sel)
                                 |=> !vdisp)
      else $error("odd field opened on nominal line");

   // auto gate with text only lets parity through
   a_auto_text: assert property (ce && !field_out_force_low && field_out_auto_gate // R5
                                 && !video_on |=> field_out == $past(raw_odd))
      else $error("field output gated without video");

   // status read returns latched parity and system
   a_status_bits: assert property (ce && rd_stb && addr == ADDR_W'(tds_pkg::REG_STATUS) // R17
                                   |=> rdata[tds_pkg::ST_ODD] == $past(raw_odd)
                                   && rdata[tds_pkg::ST_525] == $past(mode_525))
      else $error("status read wrong");

   // read data stand one cycle only
   a_rdata_idle: assert property (ce && !rd_stb |=> rdata == '0)
      else $error("read data left standing");

   // a write to REG_CTRL_A lands in display_ctrl_a
   a_write_lands: assert property (ce && wr_stb && addr == ADDR_W'(tds_pkg::REG_CTRL_A)
                                   |=> display_ctrl_a == $past(wdata))
      else $error("control write lost");

   // clock enable low freezes every output
   a_ce_freeze: assert property (!ce |=> $stable(field_out) && $stable(disp_window)
                                 && $stable(rdata))
      else $error("state moved with clock enable low");
endmodule : tds_display_sync

//--- testbench/tds_scan_model.sv
// Purpose: scan circuit model that drives hsync and vsync into the block
// Assumes: run_field is called once per field; bus gaps between calls stretch the last line
// Notes: sync lines always driven, idle at the inactive level
`timescale 1ns/10ps
module tds_scan_model (
   input  wire logic sys_clk,
   input  wire logic h_pol,
   input  wire logic v_pol,
   output logic      hsync_in,
   output logic      vsync_in
);
   int vs_left = 0;

   initial begin
      hsync_in = 1'b0;
      vsync_in = 1'b0;
   end

   // one field; lines around lo and lo+250 are long so the window shows
   task automatic run_field(input int lines, input int off, input int lo, input int llen);
      int len;
      for (int ln = 1; ln <= lines; ln++) begin
         len = (ln >= lo && ln < lo + 4 || ln == lo + 250) ? llen
             : (ln == lo + 4 || ln == lo + 251) ? 1600 : 40;
         for (int c = 0; c < len; c++) begin
            @(posedge sys_clk);
            // vsync placed at a chosen phase of line 1
            if (ln == 1 && c == off) begin
               vs_left = 8;
            end
            hsync_in <= h_pol ^ (c < 4);
            vsync_in <= v_pol ^ (vs_left > 0);
            if (vs_left > 0) begin
               vs_left--;
            end
         end
      end
   endtask : run_field
endmodule : tds_scan_model

//--- testbench/tds_display_sync_tb.sv
// Purpose: self-checking bench for field output and display position
// Assumes: short lines of 40 cycles, long lines only where timing is measured
// Notes: parity checks run inside a field, since bus gaps stretch the last line
`timescale 1ns/10ps
module tds_display_sync_tb;
   logic       sys_clk, rst_b, ce, wr_stb, rd_stb, video_on, field_out, disp_window;
   logic       hsync_in, vsync_in;
   logic       hpol = 1'b0;
   logic       vpol = 1'b0;
   logic       hs_q = 1'b0;
   logic       vs_q = 1'b0;
   logic       dw_q = 1'b0;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rd_val;
   logic [8:0] line = 9'h000;
   int         cnt = 0;
   int         fails = 0;
   int         comparisons = 0;
   bit         seen [512];
   int         rise [512];
   int         wid  [512];
   int         offs [6] = '{0, 1, 19, 20, 21, 39};
   int         hp   [4] = '{tds_pkg::HPOS0_CYC, tds_pkg::HPOS1_CYC,
                            tds_pkg::HPOS2_CYC, tds_pkg::HPOS3_CYC};

   tds_display_sync i_tds_display_sync (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .hsync_in(hsync_in), .vsync_in(vsync_in), .video_on(video_on),
      .field_out(field_out), .disp_window(disp_window));
   tds_scan_model i_tds_scan_model (.sys_clk(sys_clk), .h_pol(hpol), .v_pol(vpol),
      .hsync_in(hsync_in), .vsync_in(vsync_in));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // line and window monitor; line 1 starts at the vsync edge
   always @(posedge sys_clk) begin
      hs_q <= hsync_in ^ hpol;
      vs_q <= vsync_in ^ vpol;
      dw_q <= disp_window;
      cnt  <= cnt + 1;
      if ((hsync_in ^ hpol) && !hs_q) begin
         line <= line + 9'h001;
         cnt  <= 0;
      end
      if ((vsync_in ^ vpol) && !vs_q) begin
         line <= 9'h001;
         foreach (seen[i]) seen[i] <= 1'b0;
      end
      if (disp_window && !dw_q) begin
         seen[line] <= 1'b1;
         rise[line] <= cnt;
      end
      if (!disp_window && dw_q) begin
         wid[line] <= cnt - rise[line];
      end
   end

   task automatic conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wr_stb <= 1'b1;
      addr   <= a;
      wdata  <= d;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // data is taken in the one cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      @(posedge sys_clk);
      rd_val = rdata;
   endtask : rd

   task automatic step;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : step

   // bounded wait for a given line of the current field
   task automatic wait_line(input int x);
      int n;
      n = 0;
      while (line != 9'(x)) begin
         @(posedge sys_clk);
         n++;
         if (n > 30000) begin
            fails++;
            conclude();
         end
      end
      #1;
   endtask : wait_line

   // one 300-line field; window must span lines fl to fl+249
   task automatic vfield(input int off, input int fl, input logic [7:0] pos,
                         input logic m525, input int llen);
      wr(tds_pkg::REG_POSITION, pos);
      fork
         i_tds_scan_model.run_field(300, off, fl - 1, llen);
         begin
            wait_line(10);
            rd(tds_pkg::REG_STATUS);
            chk("mode", 32'(m525), 32'(rd_val[1]));
            for (int k = 1; k < 4 && llen > 1000; k++) begin
               wait_line(fl + k);
               wr(tds_pkg::REG_POSITION, pos | 8'(k));
            end
         end
      join
      chk("before first", 32'h0, 32'(seen[fl - 1]));
      chk("first line", 32'h1, 32'(seen[fl]));
      chk("last line", 32'h1, 32'(seen[fl + 249]));
      chk("after last", 32'h0, 32'(seen[fl + 250]));
      for (int k = 0; k < 4 && llen > 1000; k++) begin
         chk("h start", rise[fl] - hp[0] + hp[k], rise[fl + k]);
         chk("h width", tds_pkg::HDISP_CYC, wid[fl + k]);
      end
   endtask : vfield

   initial begin
      rst_b    = 1'b0;
      ce       = 1'b1;
      wr_stb   = 1'b0;
      rd_stb   = 1'b0;
      addr     = 4'h0;
      wdata    = 8'h00;
      video_on = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      // reset values, status and unmapped places read zero
      for (int a = 0; a < 6; a++) begin
         rd(4'(a));
         chk("reset read", 32'h0, 32'(rd_val));
      end
      wr(tds_pkg::REG_CTRL_B, 8'h07);
      ce <= 1'b0;
      wr(tds_pkg::REG_CTRL_B, 8'h00);
      ce <= 1'b1;
      wr(tds_pkg::REG_STATUS, 8'hFF);
      wr(tds_pkg::REG_POSITION, 8'h1F);
      rd(tds_pkg::REG_CTRL_B);
      chk("ctrl_b", 32'h07, 32'(rd_val));
      rd(tds_pkg::REG_POSITION);
      chk("position", 32'h1F, 32'(rd_val));
      // the polarity flip read as one sync on each pin: a 0-line field, so 525
      rd(tds_pkg::REG_STATUS);
      chk("status ro", 32'h02, 32'(rd_val));
      wr(tds_pkg::REG_CTRL_B, 8'h00);
      // warm-up field gives the block a line length
      i_tds_scan_model.run_field(40, 0, 900, 40);
      // an exact mid-line vsync (20 of 40) still counts as first half
      foreach (offs[i]) begin
         fork
            i_tds_scan_model.run_field(40, offs[i], 900, 40);
            begin
               wait_line(30);
               chk("field_out", 32'(offs[i] >= 21), 32'(field_out));
               rd(tds_pkg::REG_STATUS);
               chk("raw odd", 32'(offs[i] >= 21), 32'(rd_val[0]));
            end
         join
      end
      // negative-going syncs; the switch itself makes a bad field
      wr(tds_pkg::REG_CTRL_B, 8'h06);
      hpol <= 1'b1;
      vpol <= 1'b1;
      i_tds_scan_model.run_field(40, 0, 900, 40);
      for (int k = 0; k < 2; k++) begin
         fork
            i_tds_scan_model.run_field(40, k * 30, 900, 40);
            begin
               wait_line(30);
               chk("neg field_out", 32'(k), 32'(field_out));
            end
         join
      end
      wr(tds_pkg::REG_CTRL_B, 8'h00);
      hpol <= 1'b0;
      vpol <= 1'b0;
      i_tds_scan_model.run_field(40, 0, 900, 40);
      // output controls inside an odd field
      fork
         i_tds_scan_model.run_field(40, 30, 900, 40);
         begin
            wait_line(4);
            wr(tds_pkg::REG_CTRL_A, 8'h01);
            step();
            chk("force low", 32'h0, 32'(field_out));
            wr(tds_pkg::REG_CTRL_A, 8'h02);
            video_on <= 1'b1;
            step();
            chk("auto video", 32'h0, 32'(field_out));
            @(posedge sys_clk);
            video_on <= 1'b0;
            step();
            chk("auto text", 32'h1, 32'(field_out));
            wr(tds_pkg::REG_CTRL_A, 8'h03);
            step();
            chk("force over auto", 32'h0, 32'(field_out));
            wr(tds_pkg::REG_CTRL_A, 8'h00);
            wr(tds_pkg::REG_CTRL_B, 8'h01);
            step();
            chk("invert ignored", 32'h1, 32'(field_out));
            wr(tds_pkg::REG_CTRL_B, 8'h00);
         end
      join
      // vertical position, mode detection and horizontal sweep
      vfield(0, 20, 8'h10, 1'b1, 480);
      vfield(0, 42, 8'h00, 1'b0, 1600);
      wr(tds_pkg::REG_CTRL_B, 8'h01);
      vfield(0, 43, 8'h00, 1'b0, 480);
      wr(tds_pkg::REG_CTRL_B, 8'h00);
      vfield(30, 41, 8'h1C, 1'b0, 480);
      conclude();
   end
endmodule : tds_display_sync_tb
